// file: src/fifo_split.sv
`timescale 1ns/100ps
`default_nettype none
module fifo_split (
    input wire logic [tx_cfg_pkg::ALLOC_W-1:0] code, // size in KB
    output logic [tx_cfg_pkg::SIZE_W-1:0] data_bytes, // tx data FIFO
    output logic [tx_cfg_pkg::SIZE_W-1:0] rx_bytes // rx FIFOs together
);
    import tx_cfg_pkg::*;

    logic [ALLOC_W-1:0] kb;
    logic [SIZE_W-1:0] tx_bytes;

    always_comb begin
        // out-of-range codes are pinned so the tx data share never wraps
        if (code < ALLOC_MIN) begin
            kb = ALLOC_MIN;
        end else if (code > ALLOC_MAX) begin
            kb = ALLOC_MAX;
        end else begin
            kb = code;
        end
        tx_bytes = {1'b0, kb, 10'h000};
        data_bytes = tx_bytes - STATUS_FIFO_BYTES;
        rx_bytes = TOTAL_FIFO_BYTES - tx_bytes;
    end

endmodule : fifo_split
`default_nettype wire

// file: src/start_threshold_sel.sv
`timescale 1ns/100ps
`default_nettype none
module start_threshold_sel #(
    parameter logic [2:0][7:0] THR_100M_UPPER = {8'h40, 8'h38, 8'h30}
) (
    input wire logic speed_sel, // 1: slow-link table
    input wire logic whole, // whole-frame buffering
    input wire logic [tx_cfg_pkg::THR_W-1:0] code, // threshold code
    input wire logic [tx_cfg_pkg::DLEVEL_W-1:0] level, // DWORDs queued
    input wire logic frame_ready, // complete frame queued
    output logic [7:0] thr_dw, // active threshold
    output logic start_ok // frame may start
);
    import tx_cfg_pkg::*;

    always_comb begin
        if (speed_sel) begin
            thr_dw = THR_10M[code];
        end else if (code == 2'b00) begin
            thr_dw = THR_100M_CODE0;
        end else begin
            thr_dw = THR_100M_UPPER[code - 2'b01];
        end
        // whole mode start_ok ignores speed and code; thr_dw still follows them
        if (whole) begin
            start_ok = frame_ready;
        end else begin
            start_ok = frame_ready || (level >= {4'h0, thr_dw});
        end
    end

endmodule : start_threshold_sel
`default_nettype wire

// file: src/tx_cfg_pkg.sv
package tx_cfg_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] TXC_OFF = 8'h70;
    localparam logic [7:0] HWS_OFF = 8'h74;
    localparam logic [7:0] IRQ_STAT_OFF = 8'h78;
    localparam logic [7:0] IRQ_CLR_OFF = 8'h7C;
    localparam logic [7:0] IRQ_EN_OFF = 8'h80;
    localparam logic [7:0] ALLOC_OFF = 8'h84;

    localparam int TXC_STS_FLUSH_BIT = 15;
    localparam int TXC_DAT_FLUSH_BIT = 14;
    localparam int TXC_OVR_ALLOW_BIT = 2;
    localparam int TXC_ON_BIT = 1;
    localparam int TXC_HALT_BIT = 0;
    localparam int HWS_SPEED_BIT = 21;
    localparam int HWS_WHOLE_BIT = 20;
    localparam int HWS_ALLOC_LSB = 16;
    localparam int HWS_THR_LSB = 12;
    localparam int ALLOC_W = 4;
    localparam int THR_W = 2;

    localparam logic [3:0] ALLOC_RST = 4'h5;
    localparam logic [3:0] ALLOC_MIN = 4'h2;
    localparam logic [3:0] ALLOC_MAX = 4'hE;
    localparam logic [14:0] STATUS_FIFO_BYTES = 15'h0200;
    localparam logic [14:0] TOTAL_FIFO_BYTES = 15'h4000;

    // start thresholds in DWORDs, index is the threshold code
    localparam logic [3:0][7:0] THR_10M = {8'h28, 8'h20, 8'h18, 8'h12};
    localparam logic [7:0] THR_100M_CODE0 = 8'h20;

    // ------------------------------------------------------------
    // interrupts and bus answers
    // ------------------------------------------------------------
    localparam int IRQ_W = 3;
    localparam int IRQ_STS_FULL = 0;
    localparam int IRQ_UNDERRUN = 1;
    localparam int IRQ_HALTED = 2;
    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;

    localparam int DLEVEL_W = 12;
    localparam int SIZE_W = 15;

    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_WAIT = 2'b01,
        ST_SEND = 2'b10
    } tx_state_t;

    typedef struct packed {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } axi_in_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } axi_out_t;

    typedef struct packed {
        logic [DLEVEL_W-1:0] data_level;
        logic frame_ready;
        logic status_full;
        logic frame_done;
        logic word_req;
    } mac_in_t;

    typedef struct packed {
        logic tx_go;
        logic status_flush;
        logic data_flush;
        logic tx_enabled;
        logic [SIZE_W-1:0] data_fifo_bytes;
        logic [SIZE_W-1:0] rx_fifo_bytes;
    } mac_out_t;

endpackage : tx_cfg_pkg

// file: src/tx_control_fifo_alloc.sv
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module tx_control_fifo_alloc (
    input wire logic aclk, // system clock
    input wire logic aresetn, // sync reset, low
    input wire tx_cfg_pkg::axi_in_t axi_i, // lite master to slave
    output tx_cfg_pkg::axi_out_t axi_o, // lite slave to master
    input wire tx_cfg_pkg::mac_in_t mac_i, // transmit path state
    output tx_cfg_pkg::mac_out_t mac_o, // transmit path control
    output logic irq // level interrupt
);
    import tx_cfg_pkg::*;

    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_held;
        logic w_held;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic ovr_allow;
        logic tx_on;
        logic halt;
        logic speed_sel;
        logic whole;
        logic [THR_W-1:0] thr;
        logic [ALLOC_W-1:0] alloc;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_en;
        logic irq;
        logic sts_flush;
        logic dat_flush;
        logic tx_go;
        logic sts_full_q;
        tx_state_t st;
        logic [SIZE_W-1:0] data_bytes;
        logic [SIZE_W-1:0] rx_bytes;
    } state_t;

    state_t s_r;
    state_t s_nxt;
    logic [31:0] wmask;
    logic [31:0] wd;
    logic do_wr;
    logic wr_txc;
    logic suspend;
    logic start_ok;
    logic underrun_ev;
    logic [7:0] thr_dw;
    logic [SIZE_W-1:0] split_data;
    logic [SIZE_W-1:0] split_rx;
    logic [IRQ_W-1:0] ev;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    start_threshold_sel u_thr (
        .speed_sel(s_r.speed_sel),
        .whole(s_r.whole),
        .code(s_r.thr),
        .level(mac_i.data_level),
        .frame_ready(mac_i.frame_ready),
        .thr_dw(thr_dw),
        .start_ok(start_ok)
    );

    fifo_split u_split (
        .code(s_r.alloc),
        .data_bytes(split_data),
        .rx_bytes(split_rx)
    );

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_mask
            assign wmask[8*g +: 8] = {8{s_r.wstrb[g]}};
        end
    endgenerate

    assign wd = s_r.wdata & wmask;
    assign do_wr = s_r.aw_held && s_r.w_held && !s_r.bvalid;
    assign wr_txc = do_wr && (s_r.awaddr[7:2] == TXC_OFF[7:2]);
    assign suspend = mac_i.status_full && !s_r.ovr_allow;
    // data ran dry while the wire still wants words
    assign underrun_ev = (s_r.st == ST_SEND) && !s_r.whole
        && mac_i.word_req && (mac_i.data_level == '0);

    function automatic logic [31:0] rd_word(input logic [7:0] a,
                                            input state_t s);
        logic [31:0] r;
        r = 32'h0000_0000;
        case ({a[7:2], 2'b00})
            TXC_OFF: begin
                // flush bits are only held as one-cycle strobes, so they read as zero
                r[TXC_OVR_ALLOW_BIT] = s.ovr_allow;
                r[TXC_ON_BIT] = s.tx_on;
                r[TXC_HALT_BIT] = s.halt;
            end
            HWS_OFF: begin
                r[HWS_SPEED_BIT] = s.speed_sel;
                r[HWS_WHOLE_BIT] = s.whole;
                r[HWS_ALLOC_LSB +: ALLOC_W] = s.alloc;
                r[HWS_THR_LSB +: THR_W] = s.thr;
            end
            IRQ_STAT_OFF: r[IRQ_W-1:0] = s.irq_stat;
            IRQ_EN_OFF: r[IRQ_W-1:0] = s.irq_en;
            ALLOC_OFF: r = {1'b0, s.rx_bytes, 1'b0, s.data_bytes};
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction : rd_word

    function automatic logic mapped(input logic [7:0] a);
        logic m;
        case ({a[7:2], 2'b00})
            TXC_OFF, HWS_OFF, IRQ_STAT_OFF: m = 1'b1;
            IRQ_CLR_OFF, IRQ_EN_OFF, ALLOC_OFF: m = 1'b1;
            default: m = 1'b0;
        endcase
        return m;
    endfunction : mapped

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.sts_flush = 1'b0;
        s_nxt.dat_flush = 1'b0;
        ev = '0;

        if (axi_i.awvalid && s_r.awready) begin
            s_nxt.aw_held = 1'b1;
            s_nxt.awaddr = axi_i.awaddr;
        end
        if (axi_i.wvalid && s_r.wready) begin
            s_nxt.w_held = 1'b1;
            s_nxt.wdata = axi_i.wdata;
            s_nxt.wstrb = axi_i.wstrb;
        end
        if (s_r.bvalid && axi_i.bready) begin
            s_nxt.bvalid = 1'b0;
        end

        if (do_wr) begin
            s_nxt.aw_held = 1'b0;
            s_nxt.w_held = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = mapped(s_r.awaddr) ? AXI_OKAY : AXI_SLVERR;
            case ({s_r.awaddr[7:2], 2'b00})
                TXC_OFF: begin
                    s_nxt.sts_flush = wd[TXC_STS_FLUSH_BIT];
                    s_nxt.dat_flush = wd[TXC_DAT_FLUSH_BIT];
                    if (wmask[TXC_OVR_ALLOW_BIT]) begin
                        s_nxt.ovr_allow = wd[TXC_OVR_ALLOW_BIT];
                    end
                    if (wmask[TXC_ON_BIT]) begin
                        s_nxt.tx_on = wd[TXC_ON_BIT];
                    end
                    // a pending halt locks the bit against the host
                    if (!s_r.halt && wd[TXC_HALT_BIT]) begin
                        s_nxt.halt = 1'b1;
                    end
                end
                HWS_OFF: begin
                    if (wmask[HWS_WHOLE_BIT]) begin
                        s_nxt.speed_sel = wd[HWS_SPEED_BIT];
                        s_nxt.whole = wd[HWS_WHOLE_BIT];
                        s_nxt.alloc = wd[HWS_ALLOC_LSB +: ALLOC_W];
                    end
                    if (wmask[HWS_THR_LSB]) begin
                        s_nxt.thr = wd[HWS_THR_LSB +: THR_W];
                    end
                end
                IRQ_CLR_OFF: s_nxt.irq_stat = s_r.irq_stat & ~wd[IRQ_W-1:0];
                IRQ_EN_OFF: begin
                    if (wmask[0]) begin
                        s_nxt.irq_en = wd[IRQ_W-1:0];
                    end
                end
                default: s_nxt.bresp = s_nxt.bresp;
            endcase
        end
        s_nxt.awready = !s_nxt.aw_held;
        s_nxt.wready = !s_nxt.w_held;

        if (s_r.rvalid && axi_i.rready) begin
            s_nxt.rvalid = 1'b0;
            s_nxt.arready = 1'b1;
        end
        if (axi_i.arvalid && s_r.arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.arready = 1'b0;
            s_nxt.rdata = rd_word(axi_i.araddr, s_r);
            s_nxt.rresp = mapped(axi_i.araddr) ? AXI_OKAY : AXI_SLVERR;
        end

        case (s_r.st)
            ST_OFF: begin
                if (s_r.tx_on && !s_r.halt) begin
                    s_nxt.st = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!s_r.tx_on || s_r.halt) begin
                    s_nxt.st = ST_OFF;
                end else if (start_ok && !suspend) begin
                    s_nxt.st = ST_SEND;
                end
            end
            ST_SEND: begin
                // the frame in flight always runs to its end
                if (mac_i.frame_done) begin
                    s_nxt.st = ST_WAIT;
                end
            end
            default: s_nxt.st = ST_OFF;
        endcase

        // halt completes only between frames
        if (s_r.halt && (s_r.st != ST_SEND)) begin
            s_nxt.halt = 1'b0;
            s_nxt.tx_on = 1'b0;
            s_nxt.st = ST_OFF;
            ev[IRQ_HALTED] = 1'b1;
        end

        s_nxt.tx_go = (s_nxt.st == ST_SEND) && !suspend;
        s_nxt.sts_full_q = mac_i.status_full;
        ev[IRQ_STS_FULL] = mac_i.status_full && !s_r.sts_full_q;
        ev[IRQ_UNDERRUN] = underrun_ev;
        // a new event beats a clear in the same cycle
        s_nxt.irq_stat = s_nxt.irq_stat | ev;
        s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_en);
        s_nxt.data_bytes = split_data;
        s_nxt.rx_bytes = split_rx;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
            s_r.awready <= 1'b1;
            s_r.wready <= 1'b1;
            s_r.arready <= 1'b1;
            s_r.alloc <= ALLOC_RST;
            s_r.st <= ST_OFF;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign axi_o.awready = s_r.awready;
    assign axi_o.wready = s_r.wready;
    assign axi_o.bresp = s_r.bresp;
    assign axi_o.bvalid = s_r.bvalid;
    assign axi_o.arready = s_r.arready;
    assign axi_o.rdata = s_r.rdata;
    assign axi_o.rresp = s_r.rresp;
    assign axi_o.rvalid = s_r.rvalid;
    assign mac_o.tx_go = s_r.tx_go;
    assign mac_o.status_flush = s_r.sts_flush;
    assign mac_o.data_flush = s_r.dat_flush;
    assign mac_o.tx_enabled = s_r.tx_on;
    assign mac_o.data_fifo_bytes = s_r.data_bytes;
    assign mac_o.rx_fifo_bytes = s_r.rx_bytes;
    assign irq = s_r.irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sts_flush_a: assert property (wr_txc && wd[TXC_STS_FLUSH_BIT]
        |=> mac_o.status_flush ##1 !mac_o.status_flush)
        else $error("status flush pulse wrong");
    dat_flush_a: assert property (wr_txc && wd[TXC_DAT_FLUSH_BIT]
        |=> mac_o.data_flush ##1 !mac_o.data_flush)
        else $error("data flush pulse wrong");
    suspend_go_a: assert property (suspend |=> !mac_o.tx_go)
        else $error("sent while status FIFO full");
    full_irq_a: assert property (
        mac_i.status_full && !s_r.sts_full_q |=> s_r.irq_stat[IRQ_STS_FULL])
        else $error("status full event lost");
    start_send_a: assert property ((s_r.st == ST_WAIT)
        && s_r.tx_on && !s_r.halt && start_ok && !suspend
        |=> (s_r.st == ST_SEND) ##1 (mac_o.tx_go || $past(suspend)))
        else $error("ready frame not started");
    halt_done_a: assert property (
        s_r.halt && (s_r.st != ST_SEND) |=> !s_r.halt && !mac_o.tx_enabled)
        else $error("halt did not complete");
    halt_frame_a: assert property (
        s_r.halt && (s_r.st == ST_SEND) && !mac_i.frame_done |=> s_r.halt)
        else $error("halt left frame early");
    halt_lock_a: assert property (wr_txc && s_r.halt
        && !wd[TXC_HALT_BIT] && (s_r.st == ST_SEND) |=> s_r.halt)
        else $error("host cleared pending halt");
    whole_wait_a: assert property ((s_r.st == ST_WAIT)
        && s_r.whole && !mac_i.frame_ready |=> s_r.st != ST_SEND)
        else $error("partial frame started in whole mode");
    thr_wait_a: assert property ((s_r.st == ST_WAIT) && !s_r.whole
        && !mac_i.frame_ready && (mac_i.data_level < {4'h0, thr_dw})
        |=> s_r.st != ST_SEND)
        else $error("started below threshold");
    slow_table_a: assert property (!s_r.whole && s_r.speed_sel
        && (s_r.thr == 2'b11) && (mac_i.data_level == 12'h028)
        && (s_r.st == ST_WAIT) && s_r.tx_on && !s_r.halt && !suspend
        |=> s_r.st == ST_SEND)
        else $error("slow table code 3 not 028h");
    underrun_a: assert property (underrun_ev
        |=> s_r.irq_stat[IRQ_UNDERRUN] ##1 s_r.irq_stat[IRQ_UNDERRUN]
        || $past(do_wr))
        else $error("underrun not flagged");
    alloc_sum_a: assert property ($stable(s_r.alloc)
        |=> (17'(s_r.data_bytes) + 17'(STATUS_FIFO_BYTES)
        + 17'(s_r.rx_bytes)) == 17'(TOTAL_FIFO_BYTES))
        else $error("fifo split does not total 16KB");
    alloc_clamp_a: assert property ($stable(s_r.alloc)
        |=> (s_r.data_bytes >= 15'h0600) && (s_r.data_bytes <= 15'h3600))
        else $error("tx data FIFO size out of range");
    irq_level_a: assert property (irq == |(s_r.irq_stat & s_r.irq_en))
        else $error("interrupt level mismatch");

    halt_seq_c: cover property (s_r.halt && (s_r.st == ST_SEND)
        ##[1:40] !s_r.halt && !s_r.tx_on);
    underrun_c: cover property (underrun_ev);
    flush_c: cover property (mac_o.status_flush && mac_o.data_flush);
    send_c: cover property ((s_r.st == ST_WAIT) ##1 (s_r.st == ST_SEND));
    halt_lock_c: cover property (wr_txc && s_r.halt && (s_r.st == ST_SEND));

endmodule : tx_control_fifo_alloc
`default_nettype wire

// file: verification/mac_path_model.sv
`timescale 1ns/100ps
`default_nettype none
module mac_path_model (
    input wire logic aclk, // system clock
    input wire logic aresetn, // sync reset, low
    input wire logic tx_go, // frame on the wire
    input wire logic [tx_cfg_pkg::DLEVEL_W-1:0] level, // DWORDs queued
    input wire logic frame_ready, // whole frame queued
    input wire logic status_full, // status FIFO full
    output var tx_cfg_pkg::mac_in_t mac_i // to the block
);
    import tx_cfg_pkg::*;
    // 16-beat frames: long enough for a halt to land mid-frame
    logic [3:0] beat_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            beat_r <= 4'h0;
        end else if (tx_go) begin
            beat_r <= beat_r + 4'h1;
        end
    end
    always_comb begin
        mac_i.data_level = level;
        mac_i.frame_ready = frame_ready;
        mac_i.status_full = status_full;
        mac_i.frame_done = tx_go && (beat_r == 4'hF);
        mac_i.word_req = tx_go && beat_r[0];
    end
endmodule : mac_path_model
`default_nettype wire

// file: verification/tb_tx_control_fifo_alloc.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
    err_count++; $display("[FAIL] %0t got %0h exp %0h", $time, g, e); \
    end end
module tb_tx_control_fifo_alloc;
    import tx_cfg_pkg::*;
    logic aclk, aresetn, irq, frdy, sfull;
    axi_in_t axi_i;
    axi_out_t axi_o;
    mac_in_t mac_i;
    mac_out_t mac_o;
    logic [11:0] lvl;
    logic [1:0] bresp_r;
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;
    int sfl_n = 0;
    int dfl_n = 0;
    logic [7:0] thr_tbl [5] = '{8'h12, 8'h18, 8'h20, 8'h28, 8'h20};

    tx_control_fifo_alloc i_tx_control_fifo_alloc (.aclk(aclk),
        .aresetn(aresetn), .axi_i(axi_i), .axi_o(axi_o), .mac_i(mac_i),
        .mac_o(mac_o), .irq(irq));
    mac_path_model i_mac_path_model (.aclk(aclk), .aresetn(aresetn),
        .tx_go(mac_o.tx_go), .level(lvl), .frame_ready(frdy),
        .status_full(sfull), .mac_i(mac_i));

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    // flush strobes last one cycle, so count them as they pass
    always @(posedge aclk) begin
        cyc++;
        if (mac_o.status_flush === 1'b1) sfl_n++;
        if (mac_o.data_flush === 1'b1) dfl_n++;
        if (cyc > 6000) begin
            err_count++;
            complete_run();
        end
    end

    // ------------------------------------------------------------
    // bus tasks; bready and rready stay high throughout
    // ------------------------------------------------------------
    task wr(input logic [7:0] a, input logic [31:0] d);
        axi_i.awaddr <= a;
        axi_i.wdata <= d;
        axi_i.wstrb <= 4'hF;
        axi_i.awvalid <= 1'b1;
        axi_i.wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (axi_i.awvalid && axi_o.awready) axi_i.awvalid <= 1'b0;
            if (axi_i.wvalid && axi_o.wready) axi_i.wvalid <= 1'b0;
        end while (axi_o.bvalid !== 1'b1);
        bresp_r = axi_o.bresp;
    endtask : wr

    task rd_chk(input logic [7:0] a, input logic [31:0] e,
                input logic [1:0] r);
        axi_i.araddr <= a;
        axi_i.arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (axi_o.arready) axi_i.arvalid <= 1'b0;
        end while (axi_o.rvalid !== 1'b1);
        `CHK(axi_o.rdata, e)
        `CHK(axi_o.rresp, r)
    endtask : rd_chk

    // samples pre-edge values, so no race with the design's flops
    task wait_sig(input bit en, input logic e);
        logic v;
        int k;
        k = 0;
        v = ~e;
        while (v !== e && k < 40) begin
            @(posedge aclk);
            v = en ? mac_o.tx_enabled : mac_o.tx_go;
            k++;
        end
        `CHK(v, e)
    endtask : wait_sig

    task complete_run;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        aresetn = 1'b0;
        axi_i = '0;
        axi_i.bready = 1'b1;
        axi_i.rready = 1'b1;
        lvl = 12'h000;
        frdy = 1'b0;
        sfull = 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd_chk(TXC_OFF, 32'h0000_0000, AXI_OKAY);
        rd_chk(HWS_OFF, 32'h0005_0000, AXI_OKAY);
        rd_chk(ALLOC_OFF, 32'h2C00_1200, AXI_OKAY);
        wr(HWS_OFF, 32'h000E_0000);
        rd_chk(ALLOC_OFF, 32'h0800_3600, AXI_OKAY);
        `CHK(mac_o.data_fifo_bytes, 15'h3600)
        `CHK(mac_o.rx_fifo_bytes, 15'h0800)
        wr(HWS_OFF, 32'h000F_0000);
        rd_chk(ALLOC_OFF, 32'h0800_3600, AXI_OKAY);
        wr(HWS_OFF, 32'h0002_0000);
        rd_chk(ALLOC_OFF, 32'h3800_0600, AXI_OKAY);
        wr(ALLOC_OFF, 32'hFFFF_FFFF);
        `CHK(bresp_r, AXI_OKAY)
        rd_chk(ALLOC_OFF, 32'h3800_0600, AXI_OKAY);
        wr(8'h40, 32'h0000_0001);
        `CHK(bresp_r, AXI_SLVERR)
        rd_chk(8'h40, 32'h0000_0000, AXI_SLVERR);
        wr(TXC_OFF, 32'h0000_8000);
        repeat (2) @(posedge aclk);
        `CHK(sfl_n, 1)
        `CHK(dfl_n, 0)
        wr(TXC_OFF, 32'h0000_4000);
        repeat (2) @(posedge aclk);
        `CHK(dfl_n, 1)
        rd_chk(TXC_OFF, 32'h0000_0000, AXI_OKAY);
        wr(IRQ_EN_OFF, 32'h0000_0007);
        wr(TXC_OFF, 32'h0000_0002);
        `CHK(mac_o.tx_enabled, 1'b1)
        // ascending thresholds; index 4 is the fast-link code 0
        for (int i = 0; i < 5; i++) begin
            wr(HWS_OFF, {10'h0, i < 4, 1'b0, 4'h5, 4'h0 | i[1:0], 12'h0});
            lvl <= {4'h0, thr_tbl[i] - 8'h01};
            repeat (6) @(posedge aclk);
            `CHK(mac_o.tx_go, 1'b0)
            lvl <= {4'h0, thr_tbl[i]};
            wait_sig(1'b0, 1'b1);
            lvl <= {4'h0, thr_tbl[i] - 8'h01};
            wait_sig(1'b0, 1'b0);
            lvl <= 12'h000;
        end
        wr(HWS_OFF, 32'h0035_0000);
        lvl <= 12'hFFF;
        repeat (6) @(posedge aclk);
        `CHK(mac_o.tx_go, 1'b0)
        frdy <= 1'b1;
        wait_sig(1'b0, 1'b1);
        frdy <= 1'b0;
        wait_sig(1'b0, 1'b0);
        sfull <= 1'b1;
        lvl <= 12'h000;
        wr(HWS_OFF, 32'h0025_0000);
        lvl <= 12'h100;
        repeat (6) @(posedge aclk);
        `CHK(mac_o.tx_go, 1'b0)
        rd_chk(IRQ_STAT_OFF, 32'h0000_0001, AXI_OKAY);
        `CHK(irq, 1'b1)
        wr(TXC_OFF, 32'h0000_0006);
        wait_sig(1'b0, 1'b1);
        wr(IRQ_CLR_OFF, 32'h0000_0001);
        sfull <= 1'b0;
        @(posedge aclk);
        sfull <= 1'b1;
        repeat (2) @(posedge aclk);
        rd_chk(IRQ_STAT_OFF, 32'h0000_0001, AXI_OKAY);
        lvl <= 12'h000;
        repeat (4) @(posedge aclk);
        rd_chk(IRQ_STAT_OFF, 32'h0000_0003, AXI_OKAY);
        wait_sig(1'b0, 1'b0);
        lvl <= 12'h100;
        wait_sig(1'b0, 1'b1);
        wr(TXC_OFF, 32'h0000_0007);
        wr(TXC_OFF, 32'h0000_0006);
        rd_chk(TXC_OFF, 32'h0000_0007, AXI_OKAY);
        `CHK(mac_o.tx_enabled, 1'b1)
        wait_sig(1'b1, 1'b0);
        `CHK(mac_o.tx_go, 1'b0)
        rd_chk(TXC_OFF, 32'h0000_0004, AXI_OKAY);
        rd_chk(IRQ_STAT_OFF, 32'h0000_0007, AXI_OKAY);
        wr(IRQ_EN_OFF, 32'h0000_0000);
        `CHK(irq, 1'b0)
        wr(IRQ_CLR_OFF, 32'h0000_0007);
        wr(IRQ_EN_OFF, 32'h0000_0007);
        `CHK(irq, 1'b0)
        rd_chk(IRQ_STAT_OFF, 32'h0000_0000, AXI_OKAY);
        complete_run();
    end
endmodule : tb_tx_control_fifo_alloc
`default_nettype wire
